// >>> common/epv_pkg.sv
// constants and mode codes of the otp block
`default_nettype none
package epv_pkg;
    // ------------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------------
    localparam int unsigned CODE_DEPTH = 4096;        // code bytes
    localparam int unsigned ADDR_W     = 12;          // code address width
    localparam int unsigned KEY_DEPTH  = 64;          // encryption bytes
    localparam int unsigned KEY_W      = 6;           // encryption index width
    localparam logic [7:0]  ERASED_BYTE = 8'hff;      // erased array reads ones
    localparam int unsigned PULSES_PER_WRITE = 5;     // strobe pulses per byte

    // ------------------------------------------------------------------
    // identification bytes
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 12'h030; // maker byte location
    localparam logic [ADDR_W-1:0] ID_PART_ADDR  = 12'h031; // part byte location
    localparam logic [7:0] ID_MAKER_DEFAULT = 8'h5a;  // arbitrary value
    localparam logic [7:0] ID_PART_DEFAULT  = 8'h3c;  // arbitrary value

    // ------------------------------------------------------------------
    // mode pin codes {port2 bit7, port2 bit6, port3 bit7, port3 bit6}
    // ------------------------------------------------------------------
    localparam logic [3:0] PINS_SIGNATURE = 4'h0;     // read identification
    localparam logic [3:0] PINS_PGM_CODE  = 4'hb;     // write code byte
    localparam logic [3:0] PINS_VERIFY    = 4'h3;     // read code byte
    localparam logic [3:0] PINS_PGM_KEY   = 4'ha;     // write encryption byte
    localparam logic [3:0] PINS_PGM_SB1   = 4'hf;     // set security bit 1
    localparam logic [3:0] PINS_PGM_SB2   = 4'hc;     // set security bit 2
    localparam logic [3:0] PINS_PGM_SB3   = 4'h5;     // set security bit 3

    // ------------------------------------------------------------------
    // decoded operating mode, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        MODE_IDLE      = 8'h01,
        MODE_SIGNATURE = 8'h02,
        MODE_VERIFY    = 8'h04,
        MODE_PGM_CODE  = 8'h08,
        MODE_PGM_KEY   = 8'h10,
        MODE_PGM_SB1   = 8'h20,
        MODE_PGM_SB2   = 8'h40,
        MODE_PGM_SB3   = 8'h80
    } epv_mode_type;

    // ------------------------------------------------------------------
    // axi4-lite register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CTRL_ADDR   = 8'h00;   // control
    localparam logic [7:0] REG_STATUS_ADDR = 8'h04;   // security and mode state
    localparam logic [7:0] REG_COUNT_ADDR  = 8'h08;   // commit and refuse counts
    localparam int unsigned CTRL_PGM_EN_BIT = 0;      // pin programming enable
    localparam logic        CTRL_PGM_EN_RST = 1'b1;   // enabled after reset
    localparam int unsigned STAT_SB_LSB    = 0;       // security bits [2:0]
    localparam int unsigned STAT_KEYED_BIT = 3;       // table holds a value
    localparam int unsigned STAT_MODE_LSB  = 8;       // one-hot mode [15:8]
    localparam int unsigned STAT_CNT_LSB   = 16;      // pulse count [19:16]
    localparam logic [1:0]  RESP_OKAY      = 2'h0;    // axi okay
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;    // axi slave error
endpackage : epv_pkg
`default_nettype wire

// >>> rtl/epv_strobe_seq.sv
// strobe pulse counter, commit after the fifth
`timescale 1ns/1ps
`default_nettype none
module epv_strobe_seq
#(
    parameter int unsigned PULSES = epv_pkg::PULSES_PER_WRITE
)
(
    input  wire logic       i_core_clk,   // core clock
    input  wire logic       i_sys_rst,    // async reset, high
    input  wire logic       i_strobe,     // synchronised strobe level
    input  wire logic       i_arm,        // a programming mode is selected
    output logic            o_commit,     // one-cycle pulse, fifth pulse ended
    output logic [3:0]      o_count       // pulses seen so far
);
    import epv_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic       strobe_last_reg;          // previous strobe level
    logic [3:0] count_reg;                // pulse counter
    logic [3:0] count_next;               // its next value
    logic       commit_reg;               // commit pulse
    wire        rise = i_strobe & ~strobe_last_reg; // end of a low pulse
    wire        last = (count_reg == 4'(PULSES - 1));

    // restart when write levels drop
    assign count_next = !i_arm ? 4'h0 :
                        rise   ? (last ? 4'h0 : count_reg + 4'h1) :
                                 count_reg;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // count at pulse end (rising edge)
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            strobe_last_reg <= 1'b1;
            count_reg       <= 4'h0;
            commit_reg      <= 1'b0;
        end
        else
        begin
            strobe_last_reg <= i_strobe;
            count_reg       <= count_next;
            commit_reg      <= i_arm & rise & last; // [RL5]
        end
    end

    assign o_commit = commit_reg;
    assign o_count  = count_reg;
endmodule : epv_strobe_seq
`default_nettype wire

// >>> rtl/epv_program_verify.sv
// otp code memory program and verify interface with axi4-lite status port
// Operation
// RL1 - two identification bytes readable by programmer
// RL2 - programmer keeps oscillator running, 4-6 MHz
// RL3 - address on ports 1,2, data port 0
// RL4 - programmer holds write mode pin levels
// RL5 - five strobe pulses commit one byte
// RL6 - table loaded by five-pulse writes, 0-1F; code keeps 64 bytes, 0-3F; here the table holds 64 bytes, 0-3F, the code array 4096
// RL7 - verify returns code xnor table byte
// RL8 - encryption table never readable
// RL9 - security bit set by five-pulse write
// RL10 - any security bit locks code, table
// RL11 - verify only while bits 2,3 clear
// RL12 - verify drives addressed byte on port 0
// RL13 - programmer pulls up port 0
// RL14 - identification at 030/031, port3 bits low
// RL15 - programmer pulses 100us low, 10us high; the model pulses four cycles low, four high
// RL16 - all three bits block external execution
// RL17 - erased table reads ones, plain code
// RL18 - low address bits pick table byte
// RL19 - synchronous sampling, locked writes ignored
`timescale 1ns/1ps
`default_nettype none
module epv_program_verify
#(
    parameter logic [7:0] ID_MAKER = epv_pkg::ID_MAKER_DEFAULT, // arbitrary value
    parameter logic [7:0] ID_PART  = epv_pkg::ID_PART_DEFAULT   // arbitrary value
)
(
    input  wire logic        i_core_clk,                  // 20 MHz core clock
    input  wire logic        i_sys_rst,                   // async reset, high
    // programming pins
    input  wire logic        i_rst_pin,                   // device reset pin
    input  wire logic        i_program_store_strobe_n,    // store strobe pin
    input  wire logic        i_latch_program_strobe,      // latch/program strobe
    input  wire logic        i_external_access_supply_pin,// supply pin level
    input  wire logic [7:0]  i_port1,                     // address low
    input  wire logic [7:0]  i_port2,                     // address high, modes
    input  wire logic        i_port3_bit6,                // mode pin
    input  wire logic        i_port3_bit7,                // mode pin
    input  wire logic [7:0]  i_port0,                     // data in
    output logic [7:0]       o_port0,                     // data out, always low
    output logic [7:0]       o_port0_oe_n,                // low pulls bit low
    output logic             o_movc_block,                // internal fetch lock
    output logic             o_ea_latch_on_reset,         // latch ea at reset
    output logic             o_external_exec_block,       // external fetch lock
    // axi4-lite slave
    input  wire logic [7:0]  i_s_axi_awaddr,
    input  wire logic        i_s_axi_awvalid,
    output logic             o_s_axi_awready,
    input  wire logic [31:0] i_s_axi_wdata,
    input  wire logic [3:0]  i_s_axi_wstrb,
    input  wire logic        i_s_axi_wvalid,
    output logic             o_s_axi_wready,
    output logic [1:0]       o_s_axi_bresp,
    output logic             o_s_axi_bvalid,
    input  wire logic        i_s_axi_bready,
    input  wire logic [7:0]  i_s_axi_araddr,
    input  wire logic        i_s_axi_arvalid,
    output logic             o_s_axi_arready,
    output logic [31:0]      o_s_axi_rdata,
    output logic [1:0]       o_s_axi_rresp,
    output logic             o_s_axi_rvalid,
    input  wire logic        i_s_axi_rready
);
    import epv_pkg::*;

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int unsigned PIN_W = 30;               // all sampled pins
    logic [PIN_W-1:0] pin_meta_reg;                   // first stage
    logic [PIN_W-1:0] pin_sync_reg;                   // second stage
    wire  [PIN_W-1:0] pin_raw = {i_rst_pin, i_program_store_strobe_n,
                                 i_latch_program_strobe, i_external_access_supply_pin,
                                 i_port1, i_port2, i_port3_bit6, i_port3_bit7, i_port0};

    // two flops on every pin before use
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end
        else
        begin
            pin_meta_reg <= pin_raw;                  // [RL19]
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire              s_rst    = pin_sync_reg[29];    // reset pin level
    wire              s_program_store_strobe_n_n = pin_sync_reg[28];    // store strobe level
    wire              s_strobe = pin_sync_reg[27];    // latch/program level
    wire              s_supply = pin_sync_reg[26];    // supply pin level
    wire [7:0]        s_port1  = pin_sync_reg[25:18];
    wire [7:0]        s_port2  = pin_sync_reg[17:10];
    wire              s_p3b6   = pin_sync_reg[9];
    wire              s_p3b7   = pin_sync_reg[8];
    wire [7:0]        s_data   = pin_sync_reg[7:0];   // port 0
    wire [ADDR_W-1:0] s_addr   = {s_port2[3:0], s_port1}; // [RL3]
    wire [3:0]        s_pins   = {s_port2[7], s_port2[6], s_p3b7, s_p3b6};

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    // reads need strobe high; every mode needs the supply raised
    function automatic epv_mode_type decode_mode(input logic [3:0] pins,
                                                 input logic rst, input logic program_store_strobe_n_n,
                                                 input logic supply);
        epv_mode_type m;
        m = MODE_IDLE;
        if (rst && !program_store_strobe_n_n && supply)
        begin
            case (pins)
                PINS_SIGNATURE: m = MODE_SIGNATURE;   // [RL14]
                PINS_VERIFY:    m = MODE_VERIFY;
                PINS_PGM_CODE:  m = MODE_PGM_CODE;    // [RL4]
                PINS_PGM_KEY:   m = MODE_PGM_KEY;
                PINS_PGM_SB1:   m = MODE_PGM_SB1;
                PINS_PGM_SB2:   m = MODE_PGM_SB2;
                PINS_PGM_SB3:   m = MODE_PGM_SB3;
                default:        m = MODE_IDLE;
            endcase
        end
        return m;
    endfunction : decode_mode

    epv_mode_type mode;                               // current decoded mode
    assign mode = decode_mode(s_pins, s_rst, s_program_store_strobe_n_n, s_supply);
    wire   pgm_mode = (mode > MODE_VERIFY);          // write modes

    // ------------------------------------------------------------------
    // strobe sequencing
    // ------------------------------------------------------------------
    logic       commit;                               // byte commit pulse
    logic [3:0] pulse_cnt;                            // pulses counted
    logic       ctrl_pgm_en_reg;                      // software gate

    epv_strobe_seq #(.PULSES(PULSES_PER_WRITE)) u_seq
    (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_strobe   (s_strobe),
        .i_arm      (pgm_mode && ctrl_pgm_en_reg),
        .o_commit   (commit),
        .o_count    (pulse_cnt)
    );

    // ------------------------------------------------------------------
    // storage and security state
    // ------------------------------------------------------------------
    logic [7:0] code_mem [CODE_DEPTH];                // code array
    logic [7:0] key_mem  [KEY_DEPTH];                 // encryption table
    logic [2:0] sb_reg;                               // security bits 3..1
    logic       keyed_reg;                            // a table byte other than ff written
    logic [7:0] commit_cnt_reg;                       // accepted writes
    logic [7:0] refuse_cnt_reg;                       // locked writes

    wire locked     = |sb_reg;                        // [RL10]
    wire data_write = commit && !locked &&
                      ((mode == MODE_PGM_CODE) || (mode == MODE_PGM_KEY));
    wire sb_write   = commit && (mode >= MODE_PGM_SB1);      // [RL9]
    wire refused    = commit && !data_write && !sb_write;    // [RL19]
    wire [KEY_W-1:0] key_idx = s_addr[KEY_W-1:0];     // [RL18]

    // code and table writes only clear bits; security bit writes only set them
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            for (int i = 0; i < CODE_DEPTH; i++)
                code_mem[i] <= ERASED_BYTE;
            for (int i = 0; i < KEY_DEPTH; i++)
                key_mem[i] <= ERASED_BYTE;            // [RL17]
            sb_reg         <= 3'h0;
            keyed_reg      <= 1'b0;
            commit_cnt_reg <= 8'h00;
            refuse_cnt_reg <= 8'h00;
        end
        else
        begin
            if (data_write && (mode == MODE_PGM_CODE))
                code_mem[s_addr] <= code_mem[s_addr] & s_data;  // [RL5]
            if (data_write && (mode == MODE_PGM_KEY))
            begin
                key_mem[key_idx] <= key_mem[key_idx] & s_data;  // [RL6]
                keyed_reg        <= keyed_reg | (s_data != ERASED_BYTE);
            end
            if (sb_write)
                sb_reg <= sb_reg | {mode == MODE_PGM_SB3, mode == MODE_PGM_SB2,
                                    mode == MODE_PGM_SB1};
            if (data_write || sb_write)
                commit_cnt_reg <= commit_cnt_reg + 8'h01;
            if (refused)
                refuse_cnt_reg <= refuse_cnt_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // read path onto port 0
    // ------------------------------------------------------------------
    wire       verify_ok = !sb_reg[1] && !sb_reg[2];  // [RL11]
    // table bytes reach the pins only folded into code data
    wire [7:0] code_out  = code_mem[s_addr] ~^ key_mem[key_idx]; // [RL7] [RL8]
    wire [7:0] id_out    = (s_addr == ID_MAKER_ADDR) ? ID_MAKER :
                           (s_addr == ID_PART_ADDR)  ? ID_PART  : ERASED_BYTE; // [RL1]
    wire       rd_sig    = (mode == MODE_SIGNATURE) && s_strobe;
    wire       rd_ver    = (mode == MODE_VERIFY) && s_strobe && verify_ok;
    logic [7:0] p0_val_reg;                           // byte on port 0
    logic       p0_drive_reg;                         // port 0 active

    // open drain, pull-ups give ones
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            p0_val_reg   <= ERASED_BYTE;
            p0_drive_reg <= 1'b0;
        end
        else
        begin
            p0_drive_reg <= rd_sig || rd_ver;
            p0_val_reg   <= rd_sig ? id_out : code_out;  // [RL12] [RL14]
        end
    end

    assign o_port0      = 8'h00;
    assign o_port0_oe_n = ~({8{p0_drive_reg}} & ~p0_val_reg);
    assign o_movc_block          = sb_reg[0];
    assign o_ea_latch_on_reset   = sb_reg[0];
    assign o_external_exec_block = &sb_reg;           // [RL16]

    // ------------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------------
    logic        aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
    logic [7:0]  awaddr_reg;                          // held write address
    logic [31:0] wdata_reg;                           // held write data
    logic [3:0]  wstrb_reg;                           // held strobes
    logic [1:0]  bresp_reg, rresp_reg;
    logic [31:0] rdata_reg;

    wire        do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    wire        wr_hit   = (awaddr_reg[7:2] == REG_CTRL_ADDR[7:2]);
    wire        rd_take  = i_s_axi_arvalid && !rvalid_reg;
    wire [31:0] status_word = {12'h000, pulse_cnt, 8'(mode), 4'h0, keyed_reg, sb_reg};
    wire        rd_ctrl  = (i_s_axi_araddr[7:2] == REG_CTRL_ADDR[7:2]);
    wire        rd_stat  = (i_s_axi_araddr[7:2] == REG_STATUS_ADDR[7:2]);
    wire        rd_cnt   = (i_s_axi_araddr[7:2] == REG_COUNT_ADDR[7:2]);
    wire [31:0] rd_word  = rd_ctrl ? {31'h0, ctrl_pgm_en_reg} :
                           rd_stat ? status_word :
                           rd_cnt  ? {16'h0000, refuse_cnt_reg, commit_cnt_reg} : 32'h0;

    // either order, answer after both
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            aw_full_reg     <= 1'b0;
            w_full_reg      <= 1'b0;
            bvalid_reg      <= 1'b0;
            awaddr_reg      <= 8'h00;
            wdata_reg       <= 32'h0;
            wstrb_reg       <= 4'h0;
            bresp_reg       <= RESP_OKAY;
            ctrl_pgm_en_reg <= CTRL_PGM_EN_RST;
        end
        else
        begin
            if (i_s_axi_awvalid && !aw_full_reg)
            begin
                aw_full_reg <= 1'b1;
                awaddr_reg  <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid && !w_full_reg)
            begin
                w_full_reg <= 1'b1;
                wdata_reg  <= i_s_axi_wdata;
                wstrb_reg  <= i_s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;  // status is read only
                if (wr_hit && wstrb_reg[0])
                    ctrl_pgm_en_reg <= wdata_reg[CTRL_PGM_EN_BIT];
            end
            else if (bvalid_reg && i_s_axi_bready)
                bvalid_reg <= 1'b0;
        end
    end

    // answer one cycle after address
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0;
            rresp_reg  <= RESP_OKAY;
        end
        else if (rd_take)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= (rd_ctrl || rd_stat || rd_cnt) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_reg && i_s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign o_s_axi_awready = !aw_full_reg;
    assign o_s_axi_wready  = !w_full_reg;
    assign o_s_axi_bvalid  = bvalid_reg;
    assign o_s_axi_bresp   = bresp_reg;
    assign o_s_axi_arready = !rvalid_reg;
    assign o_s_axi_rvalid  = rvalid_reg;
    assign o_s_axi_rdata   = rdata_reg;
    assign o_s_axi_rresp   = rresp_reg;
endmodule : epv_program_verify
`default_nettype wire

// >>> tb/epv_chk.sv
// assertions on the otp block pins and bus
`timescale 1ns/1ps
`default_nettype none
module epv_chk
(
    input wire logic       i_core_clk, i_sys_rst, i_rst_pin, i_port3_bit6, i_port3_bit7,
    input wire logic [7:0] i_port2, o_port0, o_port0_oe_n,
    input wire logic       o_movc_block, o_ea_latch_on_reset, o_external_exec_block,
    input wire logic       o_s_axi_bvalid, i_s_axi_bready, o_s_axi_rvalid, o_s_axi_arready
);
    import epv_pkg::*;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    // a read mode is on the pins
    wire logic [3:0] pins = {i_port2[7:6], i_port3_bit7, i_port3_bit6};
    wire logic       rd   = i_rst_pin && (pins == PINS_VERIFY || pins == PINS_SIGNATURE);
    a_quiet_unless_read: assert property (!$past(rd, 2) && !$past(rd, 3) && !$past(rd, 4)
        |-> o_port0_oe_n == 8'hff) else $error("port0 pulled outside a read");
    a_port0_never_high: assert property (o_port0 == 8'h00) else $error("port0 driven high");
    a_exec_needs_movc: assert property (o_external_exec_block |-> o_movc_block) else $error("exec lock alone");
    a_movc_stays_set: assert property (o_movc_block |=> o_movc_block) else $error("fetch lock lost");
    a_ea_with_movc: assert property (o_ea_latch_on_reset == o_movc_block) else $error("ea latch differs");
    a_exec_stays_set: assert property ($rose(o_external_exec_block) |=> o_external_exec_block [*8])
        else $error("exec lock lost");
    a_ar_ready_free: assert property (o_s_axi_arready == !o_s_axi_rvalid) else $error("arready wrong");
    a_b_one_beat: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid) else $error("bvalid stuck");
endmodule : epv_chk
bind epv_program_verify epv_chk i_epv_chk (.*);
`default_nettype wire

// >>> tb/epv_prog_model.sv
// programmer model driving the otp pins
`timescale 1ns/1ps
`default_nettype none
module epv_prog_model
(
    input  wire logic       i_core_clk,   // core clock
    input  wire logic [7:0] i_port0_wire, // resolved port0 level
    output logic            o_rst_pin, o_program_store_strobe_n_n, o_strobe, o_supply, o_p3_6, o_p3_7,
    output logic [7:0]      o_port0, o_port1, o_port2
);
    initial {o_rst_pin, o_program_store_strobe_n_n, o_strobe, o_supply, o_p3_6, o_p3_7, o_port1, o_port2, o_port0} = {22'h0, 8'hff};
    // present mode levels, address and data
    task automatic setup(input logic [3:0] pins, input logic [11:0] a, input logic [7:0] dat);
        @(posedge i_core_clk);
        o_rst_pin <= 1'b1;
        o_program_store_strobe_n_n  <= 1'b0;
        o_supply  <= 1'b1;
        o_strobe  <= 1'b1;
        {o_port2[7:6], o_p3_7, o_p3_6} <= pins;
        o_port2[5:0] <= {2'b00, a[11:8]};
        o_port1 <= a[7:0];
        o_port0 <= dat;
    endtask : setup
    // leave the mode
    task automatic release_pins;
        @(posedge i_core_clk);
        o_rst_pin <= 1'b0;
        o_port0   <= 8'hff;
        repeat (3) @(posedge i_core_clk);
    endtask : release_pins
    // five low pulses, four cycles low then four high
    task automatic pgm_byte(input logic [3:0] pins, input logic [11:0] a, input logic [7:0] dat);
        setup(pins, a, dat);
        repeat (4) @(posedge i_core_clk);
        repeat (5)
        begin
            o_strobe <= 1'b0;
            repeat (4) @(posedge i_core_clk);
            o_strobe <= 1'b1;
            repeat (4) @(posedge i_core_clk);
        end
        release_pins();
    endtask : pgm_byte
    // read port0 through the pull-ups
    task automatic rd_byte(input logic [3:0] pins, input logic [11:0] a, output logic [7:0] v);
        setup(pins, a, 8'hff);
        repeat (5) @(posedge i_core_clk);
        v = i_port0_wire;
        release_pins();
    endtask : rd_byte
endmodule : epv_prog_model
`default_nettype wire

// >>> tb/eprom_program_verify_test.sv
// self-checking bench of the otp block
`timescale 1ns/1ps
`default_nettype none
module eprom_program_verify_test;
    import epv_pkg::*;
    logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
    logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0, i_rst_pin, i_program_store_strobe_n, i_latch_program_strobe;
    logic i_external_access_supply_pin, i_port3_bit6, i_port3_bit7, o_movc_block, o_ea_latch_on_reset;
    logic o_external_exec_block, o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [7:0]  i_port0, i_port1, i_port2, o_port0, o_port0_oe_n, i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0, o_s_axi_rdata, d;
    logic [3:0]  i_s_axi_wstrb = 4'hf;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, r;
    int          errors = 0, samples_checked = 0;
    wire logic [7:0] p0_wire = o_port0_oe_n | o_port0; // pull-ups
    always #25 i_core_clk = ~i_core_clk;
    epv_program_verify i_epv_program_verify (.*);
    epv_prog_model i_prog (.i_core_clk(i_core_clk), .i_port0_wire(p0_wire), .o_rst_pin(i_rst_pin),
        .o_program_store_strobe_n_n(i_program_store_strobe_n), .o_strobe(i_latch_program_strobe), .o_supply(i_external_access_supply_pin),
        .o_p3_6(i_port3_bit6), .o_p3_7(i_port3_bit7), .o_port0(i_port0), .o_port1(i_port1), .o_port2(i_port2));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic vfy(input logic [3:0] pins, input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] v;
        i_prog.rd_byte(pins, a, v);
        check("port0 byte", {24'h0, v}, {24'h0, exp});
    endtask : vfy
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge i_core_clk);
        i_s_axi_awaddr  <= a;
        i_s_axi_wdata   <= dat;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid  <= 1'b1;
        i_s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
        end
        while (!o_s_axi_bvalid);
        i_s_axi_bready <= 1'b0;
        r = o_s_axi_bresp;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        @(posedge i_core_clk);
        i_s_axi_araddr  <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge i_core_clk);
            if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
        end
        while (!o_s_axi_rvalid);
        i_s_axi_rready <= 1'b0;
        d = o_s_axi_rdata;
        r = o_s_axi_rresp;
    endtask : axi_rd
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    initial
    begin
        repeat (20) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        vfy(PINS_SIGNATURE, ID_MAKER_ADDR, ID_MAKER_DEFAULT);
        vfy(PINS_SIGNATURE, ID_PART_ADDR, ID_PART_DEFAULT);
        vfy(PINS_VERIFY, 12'h005, ERASED_BYTE);
        i_prog.pgm_byte(PINS_PGM_CODE, 12'h005, 8'ha5);
        vfy(PINS_VERIFY, 12'h005, 8'ha5);
        i_prog.pgm_byte(PINS_PGM_KEY, 12'h005, 8'h0f);
        vfy(PINS_VERIFY, 12'h005, 8'h55);
        vfy(PINS_VERIFY, 12'h045, 8'h0f);
        $display("test program and encrypt done");
        i_prog.pgm_byte(PINS_PGM_SB1, 12'h000, 8'hff);
        i_prog.pgm_byte(PINS_PGM_CODE, 12'h006, 8'h00);
        vfy(PINS_VERIFY, 12'h006, 8'hff);
        check("fetch locks", {30'h0, o_movc_block, o_ea_latch_on_reset}, 32'h3);
        axi_rd(REG_STATUS_ADDR);
        check("status", d, 32'h0000_0109);
        axi_rd(REG_COUNT_ADDR);
        check("counts", d, 32'h0000_0103);
        axi_rd(8'h0c);
        check("unmapped read", {30'h0, r}, {30'h0, RESP_SLVERR});
        axi_wr(REG_CTRL_ADDR, 32'h1);
        check("ctrl write", {30'h0, r}, {30'h0, RESP_OKAY});
        axi_wr(REG_STATUS_ADDR, 32'h0);
        check("status write", {30'h0, r}, {30'h0, RESP_SLVERR});
        i_prog.pgm_byte(PINS_PGM_SB2, 12'h000, 8'hff);
        vfy(PINS_VERIFY, 12'h005, 8'hff);
        i_prog.pgm_byte(PINS_PGM_SB3, 12'h000, 8'hff);
        check("exec lock", {31'h0, o_external_exec_block}, 32'h1);
        $display("test security bits done");
        final_report();
    end
    initial
    begin
        repeat (20000) @(posedge i_core_clk);
        errors++;
        final_report();
    end
endmodule : eprom_program_verify_test
`default_nettype wire
